// [hw/dsr_relay.sv]
// Door state relay reporting core with AXI4-Lite register slave
//
// The placing of the registers and the AXI4-Lite register port were left to the implementer.
`timescale 1ns/1ps
module dsr_relay (
    input wire logic mclk_in, // 100 MHz clock
    input wire logic rst_n_in, // Async reset, active low
    input wire logic ce_in, // Clock enable, freezes state when low
    input wire logic closed_pos_in, // Controller detected closed position
    input wire logic enc_pulse_in, // Encoder pulse activity pin
    input wire logic closed_position_switch_in, // Closed switch pin
    input wire logic open_cmd_in, // Open command pin
    input wire logic obstruct_in, // Obstruction detected
    input wire logic barrier_in, // Light barrier interrupted
    input wire logic nudge_cmd_in, // Close-with-nudge move active
    input wire logic end_stop_in, // Open end stop detected
    input wire logic [15:0] open_dist_in, // Distance from open position
    output logic closed_state_relay_out, // Closed relay drive
    output logic reversal_relay_out, // Reversal relay drive
    output logic open_state_relay_out, // Open relay drive
    output logic irq_out, // Level interrupt
    input wire logic [7:0] s_axi_awaddr, // Write address
    input wire logic s_axi_awvalid, // Write address valid
    output logic s_axi_awready, // Write address ready
    input wire logic [31:0] s_axi_wdata, // Write data
    input wire logic [3:0] s_axi_wstrb, // Write strobes
    input wire logic s_axi_wvalid, // Write data valid
    output logic s_axi_wready, // Write data ready
    output logic [1:0] s_axi_bresp, // Write response
    output logic s_axi_bvalid, // Write response valid
    input wire logic s_axi_bready, // Write response ready
    input wire logic [7:0] s_axi_araddr, // Read address
    input wire logic s_axi_arvalid, // Read address valid
    output logic s_axi_arready, // Read address ready
    output logic [31:0] s_axi_rdata, // Read data
    output logic [1:0] s_axi_rresp, // Read response
    output logic s_axi_rvalid, // Read data valid
    input wire logic s_axi_rready // Read data ready
);
    dsr_sync_if sif ();

    // Pins from the door side are asynchronous to mclk
    assign sif.raw = {1'b0, end_stop_in, nudge_cmd_in, barrier_in,
                      obstruct_in, open_cmd_in, closed_position_switch_in,
                      enc_pulse_in};

    dsr_sync #(.WIDTH(8)) u_sync (
        .mclk_in(mclk_in),
        .rst_n_in(rst_n_in),
        .ce_in(ce_in),
        .bus(sif)
    );

    logic s_enc;
    logic s_closed_position_switch;
    logic s_open;
    logic s_obst;
    logic s_barr;
    logic s_nudge;
    logic s_end;
    assign s_enc = sif.synced[0];
    assign s_closed_position_switch = sif.synced[1];
    assign s_open = sif.synced[2];
    assign s_obst = sif.synced[3];
    assign s_barr = sif.synced[4];
    assign s_nudge = sif.synced[5];
    assign s_end = sif.synced[6];

    // Registered state
    logic enc_prev;
    logic [15:0] idle_cnt;
    logic closed_r;
    logic rev_r;
    logic open_r;
    logic [1:0] ctrl;
    logic [15:0] thresh;
    logic [2:0] irq_stat;
    logic [2:0] irq_mask;
    logic irq_r;
    logic aw_got;
    logic w_got;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic awready_r;
    logic wready_r;
    logic ar_got;

    logic next_enc_prev;
    logic [15:0] next_idle_cnt;
    logic next_closed_r;
    logic next_rev_r;
    logic next_open_r;
    logic [1:0] next_ctrl;
    logic [15:0] next_thresh;
    logic [2:0] next_irq_stat;
    logic [2:0] next_irq_mask;
    logic next_irq_r;
    logic next_aw_got;
    logic next_w_got;
    logic [7:0] next_aw_addr;
    logic [31:0] next_w_data;
    logic [3:0] next_w_strb;
    logic next_bvalid;
    logic [1:0] next_bresp;
    logic next_rvalid;
    logic [31:0] next_rdata;
    logic [1:0] next_rresp;
    logic next_awready;
    logic next_wready;
    logic next_ar_got;

    logic enc_stopped;
    logic near_open;
    logic open_cond;
    logic rev_trigger;
    logic do_write;
    logic rd_stat_clr;
    logic [2:0] events;
    logic [2:0] relay_now;
    logic [2:0] relay_prev;

    always_comb begin
        enc_stopped = (idle_cnt >= dsr_pkg::IDLE_CYCLES);
        near_open = (open_dist_in < thresh);
        // Idle torque mode waits for the end stop instead
        open_cond = ctrl[dsr_pkg::CTRL_IDLE_OPT] ? s_end : near_open;
        // Nudging blocks count only when the option is set
        rev_trigger = s_barr || (s_open && !closed_r)
            || (s_obst && (!s_nudge
                || ctrl[dsr_pkg::CTRL_NUDGE_OPT]));

        next_enc_prev = s_enc;
        if (s_enc != enc_prev) begin
            next_idle_cnt = 16'h0000;
        end else if (!enc_stopped) begin
            next_idle_cnt = idle_cnt + 16'h0001;
        end else begin
            next_idle_cnt = idle_cnt;
        end

        next_closed_r = closed_r;
        if (s_open) begin
            next_closed_r = 1'b0;
        end else if (closed_pos_in && (enc_stopped || s_closed_position_switch)) begin
            next_closed_r = 1'b1;
        end

        next_rev_r = rev_r;
        if (open_cond) begin
            next_rev_r = 1'b0;
        end else if (rev_trigger && !closed_pos_in) begin
            next_rev_r = 1'b1;
        end

        next_open_r = open_cond;

        relay_now = {next_open_r, next_rev_r, next_closed_r};
        relay_prev = {open_r, rev_r, closed_r};
        events = relay_now & ~relay_prev;
        next_irq_r = |(irq_stat & irq_mask);

        next_aw_got = aw_got;
        next_w_got = w_got;
        next_aw_addr = aw_addr;
        next_w_data = w_data;
        next_w_strb = w_strb;
        if (s_axi_awvalid && !aw_got) begin
            next_aw_got = 1'b1;
            next_aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !w_got) begin
            next_w_got = 1'b1;
            next_w_data = s_axi_wdata;
            next_w_strb = s_axi_wstrb;
        end
        // Ready pulses once per captured beat, frozen with the rest
        next_awready = s_axi_awvalid && !aw_got && !awready_r;
        next_wready = s_axi_wvalid && !w_got && !wready_r;
        do_write = aw_got && w_got && !bvalid;
        next_ctrl = ctrl;
        next_thresh = thresh;
        next_irq_mask = irq_mask;
        next_bvalid = bvalid;
        next_bresp = bresp;
        if (do_write) begin
            next_aw_got = 1'b0;
            next_w_got = 1'b0;
            next_bvalid = 1'b1;
            next_bresp = dsr_pkg::RESP_OKAY;
            unique case (aw_addr)
                dsr_pkg::ADDR_CTRL: begin
                    if (w_strb[0]) next_ctrl = w_data[1:0];
                end
                dsr_pkg::ADDR_IRQ_MASK: begin
                    if (w_strb[0]) next_irq_mask = w_data[2:0];
                end
                dsr_pkg::ADDR_THRESH: begin
                    if (w_strb[0]) next_thresh[7:0] = w_data[7:0];
                    if (w_strb[1]) next_thresh[15:8] = w_data[15:8];
                end
                dsr_pkg::ADDR_STAT, dsr_pkg::ADDR_IRQ_STAT: begin
                    next_bresp = dsr_pkg::RESP_OKAY;
                end
                default: next_bresp = dsr_pkg::RESP_SLVERR;
            endcase
        end else if (bvalid && s_axi_bready) begin
            next_bvalid = 1'b0;
        end

        next_rvalid = rvalid;
        next_rdata = rdata;
        next_rresp = rresp;
        next_ar_got = 1'b0;
        rd_stat_clr = 1'b0;
        // Data answers only after arready has stood for a cycle
        if (ar_got) begin
            next_rvalid = 1'b1;
        end else if (s_axi_arvalid && !rvalid) begin
            next_ar_got = 1'b1;
            next_rresp = dsr_pkg::RESP_OKAY;
            next_rdata = 32'h00000000;
            unique case (s_axi_araddr)
                dsr_pkg::ADDR_CTRL: next_rdata[1:0] = ctrl;
                dsr_pkg::ADDR_STAT: next_rdata[2:0] = relay_prev;
                dsr_pkg::ADDR_IRQ_STAT: begin
                    next_rdata[2:0] = irq_stat;
                    rd_stat_clr = 1'b1;
                end
                dsr_pkg::ADDR_IRQ_MASK: next_rdata[2:0] = irq_mask;
                dsr_pkg::ADDR_THRESH: next_rdata[15:0] = thresh;
                default: next_rresp = dsr_pkg::RESP_SLVERR;
            endcase
        end else if (rvalid && s_axi_rready) begin
            next_rvalid = 1'b0;
        end
        // New events win over the read clear
        next_irq_stat = (rd_stat_clr ? 3'h0 : irq_stat) | events;
    end

    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            enc_prev <= 1'b0;
            idle_cnt <= 16'h0000;
            closed_r <= 1'b0;
            rev_r <= 1'b0;
            open_r <= 1'b0;
            ctrl <= dsr_pkg::CTRL_RST;
            thresh <= dsr_pkg::THRESH_RST;
            irq_stat <= 3'h0;
            irq_mask <= dsr_pkg::MASK_RST;
            irq_r <= 1'b0;
            aw_got <= 1'b0;
            w_got <= 1'b0;
            aw_addr <= 8'h00;
            w_data <= 32'h00000000;
            w_strb <= 4'h0;
            bvalid <= 1'b0;
            bresp <= 2'h0;
            rvalid <= 1'b0;
            rdata <= 32'h00000000;
            rresp <= 2'h0;
            awready_r <= 1'b0;
            wready_r <= 1'b0;
            ar_got <= 1'b0;
        end else if (ce_in) begin
            enc_prev <= next_enc_prev;
            idle_cnt <= next_idle_cnt;
            closed_r <= next_closed_r;
            rev_r <= next_rev_r;
            open_r <= next_open_r;
            ctrl <= next_ctrl;
            thresh <= next_thresh;
            irq_stat <= next_irq_stat;
            irq_mask <= next_irq_mask;
            irq_r <= next_irq_r;
            aw_got <= next_aw_got;
            w_got <= next_w_got;
            aw_addr <= next_aw_addr;
            w_data <= next_w_data;
            w_strb <= next_w_strb;
            bvalid <= next_bvalid;
            bresp <= next_bresp;
            rvalid <= next_rvalid;
            rdata <= next_rdata;
            rresp <= next_rresp;
            awready_r <= next_awready;
            wready_r <= next_wready;
            ar_got <= next_ar_got;
        end
    end

    assign closed_state_relay_out = closed_r;
    assign reversal_relay_out = rev_r;
    assign open_state_relay_out = open_r;
    assign irq_out = irq_r;
    assign s_axi_awready = awready_r;
    assign s_axi_wready = wready_r;
    assign s_axi_arready = ar_got;
    assign s_axi_bvalid = bvalid;
    assign s_axi_bresp = bresp;
    assign s_axi_rvalid = rvalid;
    assign s_axi_rdata = rdata;
    assign s_axi_rresp = rresp;
endmodule : dsr_relay

// [hw/dsr_pkg.sv]
// Shared constants for the door state relay reporting block
package dsr_pkg;
    // Register byte offsets
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STAT = 8'h04;
    localparam logic [7:0] ADDR_IRQ_STAT = 8'h08;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h0C;
    localparam logic [7:0] ADDR_THRESH = 8'h10;
    // Control field positions
    localparam int CTRL_NUDGE_OPT = 0;
    localparam int CTRL_IDLE_OPT = 1;
    // Status and interrupt field positions
    localparam int ST_CLOSED = 0;
    localparam int ST_REVERSAL = 1;
    localparam int ST_OPEN = 2;
    localparam int ST_W = 3;
    // Reset values
    localparam logic [1:0] CTRL_RST = 2'h0;
    localparam logic [2:0] MASK_RST = 3'h0;
    // Open threshold in position units
    localparam logic [15:0] THRESH_RST = 16'h0014;
    // Input sync depth
    localparam int SYNC_STAGES = 2;
    // Quiet cycles before the encoder counts as stopped
    localparam logic [15:0] IDLE_CYCLES = 16'h03E8;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : dsr_pkg

// [hw/dsr_sync_if.sv]
// Interface carrying synchronised door inputs to the relay core
`timescale 1ns/1ps
interface dsr_sync_if;
    logic [7:0] raw;
    logic [7:0] synced;
    modport src (input raw, output synced);
    modport dst (output raw, input synced);
endinterface : dsr_sync_if

// [hw/dsr_sync.sv]
// Two-stage synchroniser for the door input pins
`timescale 1ns/1ps
module dsr_sync #(
    parameter int WIDTH = 8
) (
    input wire logic mclk_in, // System clock
    input wire logic rst_n_in, // Async reset, active low
    input wire logic ce_in, // Clock enable
    dsr_sync_if.src bus // Raw in, synced out
);
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
    logic [WIDTH-1:0] next_stage1;
    logic [WIDTH-1:0] next_stage2;

    always_comb begin
        next_stage1 = ce_in ? bus.raw : stage1;
        next_stage2 = ce_in ? stage1 : stage2;
    end

    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            stage1 <= '0;
            stage2 <= '0;
        end else begin
            stage1 <= next_stage1;
            stage2 <= next_stage2;
        end
    end

    assign bus.synced = stage2;
endmodule : dsr_sync

// [testbench/dsr_relay_monitor.sv]
// Assertion checker for the door state relay block
`timescale 1ns/1ps
module dsr_relay_monitor (
    input wire logic mclk_in, // Clock
    input wire logic rst_n_in, // Reset, active low
    input wire logic closed_pos_in, // Closed position
    input wire logic closed_position_switch_in, // Closed switch
    input wire logic open_cmd_in, // Open command
    input wire logic end_stop_in, // End stop
    input wire logic [15:0] open_dist_in, // Open distance
    input wire logic closed_state_relay_out, // Closed relay
    input wire logic reversal_relay_out, // Reversal relay
    input wire logic open_state_relay_out, // Open relay
    input wire logic irq_out, // Interrupt
    input wire logic s_axi_awvalid, // AW valid
    input wire logic s_axi_awready, // AW ready
    input wire logic s_axi_wvalid, // W valid
    input wire logic s_axi_wready, // W ready
    input wire logic s_axi_bvalid, // B valid
    input wire logic [7:0] s_axi_araddr, // AR address
    input wire logic s_axi_arvalid, // AR valid
    input wire logic s_axi_arready, // AR ready
    input wire logic [1:0] s_axi_rresp, // R response
    input wire logic s_axi_rvalid // R valid
);
    default clocking cb @(posedge mclk_in);
    endclocking
    default disable iff (!rst_n_in);
    a_reset_quiet: assert property ($rose(rst_n_in) |->
        !closed_state_relay_out && !reversal_relay_out &&
        !open_state_relay_out) else $error("relay on after reset");
    // Six samples cover the two sync stages plus the output register
    a_closed_set: assert property ((closed_pos_in &&
        closed_position_switch_in && !open_cmd_in)[*6] |->
        closed_state_relay_out) else $error("closed relay not set");
    a_closed_drop: assert property (open_cmd_in[*6] |->
        !closed_state_relay_out) else $error("closed relay held");
    a_open_drop: assert property ((open_dist_in >=
        dsr_pkg::THRESH_RST && !end_stop_in)[*6] |->
        !open_state_relay_out) else $error("open relay held");
    a_rev_clear: assert property (open_state_relay_out[*2] |->
        !reversal_relay_out) else $error("reversal relay held at open");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=>
        s_axi_rvalid) else $error("read answer late");
    a_write_answer: assert property (s_axi_awvalid && s_axi_awready &&
        s_axi_wvalid && s_axi_wready |-> ##[1:3] s_axi_bvalid)
        else $error("write answer late");
    a_ready_pulse: assert property (s_axi_awready |=> !s_axi_awready)
        else $error("write address ready held");
    a_read_err: assert property (s_axi_arvalid && s_axi_arready &&
        s_axi_araddr > dsr_pkg::ADDR_THRESH |=>
        s_axi_rresp == dsr_pkg::RESP_SLVERR) else $error("no error reply");
    c_closed: cover property ($rose(closed_state_relay_out));
    c_reversal: cover property ($rose(reversal_relay_out));
    c_irq: cover property ($rose(irq_out));
endmodule : dsr_relay_monitor

bind dsr_relay dsr_relay_monitor mon_u (
    .mclk_in, .rst_n_in, .closed_pos_in, .closed_position_switch_in,
    .open_cmd_in, .end_stop_in, .open_dist_in, .closed_state_relay_out,
    .reversal_relay_out, .open_state_relay_out, .irq_out, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rresp,
    .s_axi_rvalid
);

// [testbench/dsr_ctrl_model.sv]
// Model of the higher-level controller reading the relay contacts
`timescale 1ns/1ps
module dsr_ctrl_model (
    input wire logic mclk_in, // Clock
    input wire logic rst_n_in, // Reset, active low
    input wire logic [2:0] relay_in, // Contacts open, reversal, closed
    output logic [7:0] open_seen_out // Open reports counted
);
    logic [2:0] last;
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            last <= 3'h0;
            open_seen_out <= 8'h00;
        end else begin
            last <= relay_in;
            if (relay_in[2] && !last[2]) begin
                open_seen_out <= open_seen_out + 8'h01;
            end
        end
    end
endmodule : dsr_ctrl_model

// [testbench/door_state_relay_reporting_test.sv]
// Self-checking bench for the door state relay block
`timescale 1ns/1ps
module door_state_relay_reporting_test;
    logic mclk_in = 1'b0, rst_n_in = 1'b0;
    logic closed_pos_in = 1'b0, enc_pulse_in = 1'b0, open_cmd_in = 1'b0;
    logic closed_position_switch_in = 1'b0, obstruct_in = 1'b0;
    logic barrier_in = 1'b0, nudge_cmd_in = 1'b0, end_stop_in = 1'b0;
    logic [15:0] open_dist_in = 16'h0100;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0000_0000;
    logic ce_in = 1'b1;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic closed_state_relay_out, reversal_relay_out, open_state_relay_out;
    logic irq_out, s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, rrsp;
    logic [31:0] s_axi_rdata, rdat;
    logic [7:0] open_seen;
    int failures = 0, checks = 0, cycles = 0;
    dsr_relay dut_u (
        .mclk_in, .rst_n_in, .ce_in, .closed_pos_in, .enc_pulse_in,
        .closed_position_switch_in, .open_cmd_in, .obstruct_in, .barrier_in,
        .nudge_cmd_in, .end_stop_in, .open_dist_in, .closed_state_relay_out,
        .reversal_relay_out, .open_state_relay_out, .irq_out, .s_axi_awaddr,
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready
    );
    dsr_ctrl_model ctrl_u (
        .mclk_in, .rst_n_in, .open_seen_out(open_seen),
        .relay_in({open_state_relay_out, reversal_relay_out,
            closed_state_relay_out})
    );
    initial begin
        forever #5 mclk_in = ~mclk_in;
    end
    task automatic close_out;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : close_out
    always @(posedge mclk_in) begin
        cycles++;
        if (cycles > 5000) begin
            failures++;
            close_out();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("Error at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask : chk
    task automatic step(input int n);
        repeat (n) @(posedge mclk_in);
    endtask : step
    // Enough cycles for sync stages and output register to settle
    task automatic rel(input logic [2:0] e);
        step(6);
        chk({29'h0, open_state_relay_out, reversal_relay_out,
            closed_state_relay_out}, {29'h0, e});
    endtask : rel
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
            input logic [1:0] er);
        @(posedge mclk_in);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        @(posedge mclk_in);
        while (s_axi_awvalid || s_axi_wvalid || !s_axi_bvalid) begin
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            @(posedge mclk_in);
        end
        chk({30'h0, s_axi_bresp}, {30'h0, er});
        s_axi_bready <= 1'b0;
    endtask : wr
    // Address handshake comes first, the data answer after it
    task automatic rd(input logic [7:0] a, output logic [31:0] d,
            output logic [1:0] r);
        @(posedge mclk_in);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        @(posedge mclk_in);
        while (!s_axi_rvalid) begin
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            @(posedge mclk_in);
        end
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_arvalid <= 1'b0;
        s_axi_rready <= 1'b0;
    endtask : rd
    task automatic rchk(input logic [7:0] a, input logic [31:0] e);
        rd(a, rdat, rrsp);
        chk(rdat, e);
        chk({30'h0, rrsp}, {30'h0, dsr_pkg::RESP_OKAY});
    endtask : rchk
    task automatic t_regs;
        rel(3'h0);
        rchk(dsr_pkg::ADDR_THRESH, {16'h0000, dsr_pkg::THRESH_RST});
        rchk(dsr_pkg::ADDR_CTRL, 32'h0000_0000);
        rchk(dsr_pkg::ADDR_IRQ_MASK, 32'h0000_0000);
        rd(8'h20, rdat, rrsp);
        chk({30'h0, rrsp}, {30'h0, dsr_pkg::RESP_SLVERR});
        wr(8'h20, 32'h0000_0001, dsr_pkg::RESP_SLVERR);
        wr(dsr_pkg::ADDR_STAT, 32'h0000_0007, dsr_pkg::RESP_OKAY);
        rchk(dsr_pkg::ADDR_STAT, 32'h0000_0000);
        // Only the low byte lane may land
        s_axi_wstrb <= 4'h1;
        wr(dsr_pkg::ADDR_THRESH, 32'h0000_AB13, dsr_pkg::RESP_OKAY);
        s_axi_wstrb <= 4'hF;
        rchk(dsr_pkg::ADDR_THRESH, 32'h0000_0013);
        wr(dsr_pkg::ADDR_THRESH, {16'h0000, dsr_pkg::THRESH_RST},
            dsr_pkg::RESP_OKAY);
        wr(dsr_pkg::ADDR_IRQ_MASK, 32'h0000_0007, dsr_pkg::RESP_OKAY);
        rchk(dsr_pkg::ADDR_IRQ_MASK, 32'h0000_0007);
        rd(dsr_pkg::ADDR_IRQ_STAT, rdat, rrsp);
    endtask : t_regs
    task automatic t_closed;
        enc_pulse_in <= 1'b1;
        closed_pos_in <= 1'b1;
        rel(3'h0);
        step(1000);
        chk({31'h0, closed_state_relay_out}, 32'h1);
        chk({31'h0, irq_out}, 32'h1);
        rchk(dsr_pkg::ADDR_IRQ_STAT, 32'h0000_0001);
        step(2);
        chk({31'h0, irq_out}, 32'h0);
        closed_position_switch_in <= 1'b1;
        open_cmd_in <= 1'b1;
        rel(3'h0);
        open_cmd_in <= 1'b0;
        enc_pulse_in <= 1'b0;
        rel(3'h1);
        rchk(dsr_pkg::ADDR_STAT, 32'h0000_0001);
        open_cmd_in <= 1'b1;
        closed_pos_in <= 1'b0;
        closed_position_switch_in <= 1'b0;
        rel(3'h2);
        open_cmd_in <= 1'b0;
        open_dist_in <= 16'h0013;
        rel(3'h4);
        open_dist_in <= dsr_pkg::THRESH_RST;
        rel(3'h0);
    endtask : t_closed
    task automatic t_rev(input logic b, input logic o, input logic n,
            input logic e);
        barrier_in <= b;
        obstruct_in <= o;
        nudge_cmd_in <= n;
        rel({1'b0, e, 1'b0});
        barrier_in <= 1'b0;
        obstruct_in <= 1'b0;
        nudge_cmd_in <= 1'b0;
        open_dist_in <= 16'h0013;
        rel(3'h4);
        open_dist_in <= dsr_pkg::THRESH_RST;
        rel(3'h0);
    endtask : t_rev
    task automatic t_idle;
        open_dist_in <= 16'h0013;
        rel(3'h0);
        end_stop_in <= 1'b1;
        rel(3'h4);
        end_stop_in <= 1'b0;
        open_dist_in <= 16'h0100;
        rel(3'h0);
    endtask : t_idle
    // A low clock enable must hold every relay where it stands
    task automatic t_freeze;
        ce_in <= 1'b0;
        end_stop_in <= 1'b1;
        rel(3'h0);
        ce_in <= 1'b1;
        rel(3'h4);
        end_stop_in <= 1'b0;
        rel(3'h0);
    endtask : t_freeze
    initial begin
        repeat (5) @(posedge mclk_in);
        rst_n_in <= 1'b1;
        t_regs();
        t_closed();
        t_rev(1'b1, 1'b0, 1'b0, 1'b1);
        t_rev(1'b0, 1'b1, 1'b0, 1'b1);
        t_rev(1'b0, 1'b1, 1'b1, 1'b0);
        wr(dsr_pkg::ADDR_CTRL, 32'h0000_0001, dsr_pkg::RESP_OKAY);
        t_rev(1'b0, 1'b1, 1'b1, 1'b1);
        wr(dsr_pkg::ADDR_CTRL, 32'h0000_0002, dsr_pkg::RESP_OKAY);
        t_idle();
        t_freeze();
        chk({24'h0, open_seen}, 32'h7);
        close_out();
    end
endmodule : door_state_relay_reporting_test
